// ===== core/pth_timing.sv
/*
  Phase clock generator and processor-side bus handshake.
  Assumes the processor core and DMA controller sit outside; their
  requests arrive synchronous to clk_i.
*/
`timescale 1ns/1ps
module pth_timing (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  pth_bus_if.dev           bus,
  input  wire logic        cpu_req_i,
  input  wire logic        valid_addr_flag_i,
  input  wire logic        cpu_write_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [7:0]  cpu_wdata_i,
  input  wire logic        dma_stretch_i,
  output logic             phase1_o,
  output logic             phase2_o,
  output logic [7:0]       cpu_rdata_o,
  output logic             cpu_done_o,
  output logic             cpu_restart_o,
  output logic [15:0]      cpu_restart_vec_o,
  output logic             cpu_irq_n_o,
  output logic             cpu_nmi_n_o
);

  // ---------------------------------------------------------------
  // Bus clock divider
  // ---------------------------------------------------------------
  logic [19:0] acc_r;
  logic [20:0] acc_sum;
  logic        half_tick;
  logic        bclk_r;
  logic        fall;

  assign acc_sum   = {1'b0, acc_r} + {1'b0, pth_pkg::ACC_INC};
  assign half_tick = acc_sum >= {1'b0, pth_pkg::ACC_MOD};
  assign fall      = half_tick & bclk_r; // R9

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_r <= 20'h00000;
    end else if (half_tick) begin
      acc_r <= 20'(acc_sum - {1'b0, pth_pkg::ACC_MOD});
    end else begin
      acc_r <= acc_sum[19:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bclk_r <= 1'b0;
    end else if (half_tick) begin
      bclk_r <= ~bclk_r; // R8
    end
  end

  assign bus.sys_bus_clk_p = bclk_r;
  assign bus.sys_bus_clk_n = ~bclk_r;

  // ---------------------------------------------------------------
  // Johnson counter and phases
  // ---------------------------------------------------------------
  logic [3:0] jc_r;
  logic       jc_legal;
  logic       feedback;
  logic       hold;
  logic       timeout;
  logic       advance;

  always_comb begin
    unique case (jc_r)
      4'h0, 4'h1, 4'h3, 4'h7, 4'hf, 4'he, 4'hc, 4'h8: jc_legal = 1'b1;
      default:                                        jc_legal = 1'b0;
    endcase
  end

  // Bad states shift in lows until the counter is clean
  assign feedback = jc_legal & ~jc_r[3]; // R10
  assign phase1_o = feedback;            // R12
  assign phase2_o = ~feedback;           // R13
  assign advance  = fall & (~hold | timeout);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      jc_r <= pth_pkg::JC_RESET;
    end else if (advance) begin
      jc_r <= {jc_r[2:0], feedback}; // R11 R14
    end
  end

  // ---------------------------------------------------------------
  // Stretch timeout
  // ---------------------------------------------------------------
  logic [5:0] stretch_r;

  assign timeout = stretch_r >= pth_pkg::STRETCH_EXTRA; // R15 R20

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stretch_r <= 6'h00;
    end else if (advance) begin
      stretch_r <= 6'h00;
    end else if (fall && hold) begin
      stretch_r <= stretch_r + 6'h01; // R20
    end
  end

  // ---------------------------------------------------------------
  // Processor bus cycle
  // ---------------------------------------------------------------
  logic        cyc_r;
  logic        wr_r;
  logic [15:0] addr_r;
  logic [7:0]  wdata_r;
  logic        dstb_drv_r;
  logic        rd_got_r;
  logic        strobe_held;
  logic        enter_p2;
  logic        leave_p2;

  assign enter_p2    = advance & (jc_r == pth_pkg::JC_P1_LAST);
  assign leave_p2    = advance & (jc_r == pth_pkg::JC_P2_LAST);
  assign strobe_held = ~bus.data_strobe_n & ~dstb_drv_r;

  always_comb begin
    hold = 1'b0;
    if (jc_r == pth_pkg::JC_P1_LAST) begin
      hold = dma_stretch_i; // R15
    end else if (jc_r == pth_pkg::JC_P2_LAST && cyc_r) begin
      hold = wr_r ? strobe_held : ~rd_got_r; // R18 R19
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_r   <= 1'b0;
      wr_r    <= 1'b0;
      addr_r  <= 16'h0000;
      wdata_r <= 8'h00;
    end else if (enter_p2) begin
      cyc_r   <= cpu_req_i & valid_addr_flag_i; // R3
      wr_r    <= cpu_write_i;
      addr_r  <= cpu_addr_i;
      wdata_r <= cpu_wdata_i;
    end else if (leave_p2) begin
      cyc_r <= 1'b0;
    end
  end

  // Strobe launched one bus clock after data, for exactly one bus clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dstb_drv_r <= 1'b0;
    end else if (fall) begin
      dstb_drv_r <= cyc_r & wr_r & (jc_r == pth_pkg::JC_P2_FIRST) & ~dstb_drv_r; // R16
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_got_r    <= 1'b0;
      cpu_rdata_o <= 8'h00;
    end else if (enter_p2) begin
      rd_got_r <= 1'b0;
    end else if (cyc_r && !wr_r && !rd_got_r && !bus.data_strobe_n) begin
      rd_got_r    <= 1'b1;
      cpu_rdata_o <= bus.bus_data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_done_o <= 1'b0;
    end else begin
      cpu_done_o <= leave_p2 & cyc_r;
    end
  end

  // ---------------------------------------------------------------
  // Bus drivers
  // ---------------------------------------------------------------
  logic wr_line_n;

  assign wr_line_n         = ~(cyc_r & wr_r); // R4
  assign bus.dev_addr      = addr_r;
  assign bus.dev_addr_oe   = cyc_r & phase2_o;       // R7
  assign bus.dev_data      = wdata_r;
  assign bus.dev_data_oe   = cyc_r & wr_r & phase2_o; // R7
  assign bus.dev_wr_n      = wr_line_n;
  assign bus.dev_wr_oe     = phase2_o;                // R5
  assign bus.dev_dstb_oe   = dstb_drv_r;
  assign bus.addr_strobe_n = ~(cyc_r & phase2_o);     // R3 R18
  assign bus.mem_write_n   = wr_line_n;               // R6

  // ---------------------------------------------------------------
  // Processor reset and interrupts
  // ---------------------------------------------------------------
  logic restart_done_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      restart_done_r <= 1'b0;
      cpu_restart_o  <= 1'b0;
    end else begin
      restart_done_r <= 1'b1;
      cpu_restart_o  <= ~restart_done_r; // R2
    end
  end

  assign cpu_restart_vec_o = pth_pkg::RESTART_VEC; // R2
  assign cpu_irq_n_o       = bus.irq_n;            // R1
  assign cpu_nmi_n_o       = 1'b1;                 // R1

endmodule

// ===== core/pth_pkg.sv
/*
  Shared constants for the processor phase timing and bus handshake ends.
  Assumes a single 50 MHz system clock from which the bus clock is divided.
*/
// Contract
// [R1] Module interrupts reach processor only via maskable input
// [R2] Power-supply reset starts fetch at restart vector
// [R3] Address strobe only while valid address present
// [R4] Write line high reads, low writes
// [R5] Release processor write line during Phase 1
// [R6] Separately buffered write copy drives memory write strobe
// [R7] Address and data lines tri-stated for DMA sharing
// [R8] Bus clock derived from single crystal source
// [R9] Bus signals launch on bus clock falling edge
// [R10] Four-stage Johnson counter self-clears bad states
// [R11] One stage per bus clock, eight-clock pattern
// [R12] Feedback high is Phase 1, DMA owns bus
// [R13] Feedback low is Phase 2, processor owns bus
// [R14] Each phase four clocks by default
// [R15] Stretch either phase to at most maximum
// [R16] Processor write pulses data strobe one bus clock
// [R17] Slow written module holds strobe, bounded by maximum
// [R18] Held strobe keeps cycle and blocks Phase 1
// [R19] Late read data stretches Phase 2
// [R20] Stretch timeout counter forces counter advance
package pth_pkg;

  // ---------------------------------------------------------------
  // Clock rates
  // ---------------------------------------------------------------
  localparam longint SYS_HZ = 64'd50000000;
  localparam longint BUS_HZ = 64'd14745600;
  // Half-period tick accumulator, scaled by 1/100 to fit 20 bits
  localparam logic [19:0] ACC_MOD = 20'(SYS_HZ / 100);
  localparam logic [19:0] ACC_INC = 20'((2 * BUS_HZ) / 100);

  // ---------------------------------------------------------------
  // Phase timing
  // ---------------------------------------------------------------
  localparam int     PHASE_CYC       = 4;
  localparam longint STRETCH_MAX_NS  = 64'd3800;
  // Longest time, rounded down to whole bus clocks
  localparam int     STRETCH_MAX_CYC = int'((STRETCH_MAX_NS * BUS_HZ) / 64'd1000000000);
  localparam logic [5:0] STRETCH_EXTRA = 6'(STRETCH_MAX_CYC - PHASE_CYC);

  localparam logic [3:0] JC_RESET    = 4'h0;
  localparam logic [3:0] JC_P1_LAST  = 4'h7;
  localparam logic [3:0] JC_P2_FIRST = 4'hf;
  localparam logic [3:0] JC_P2_LAST  = 4'h8;

  localparam logic [15:0] RESTART_VEC = 16'hfffe;

endpackage

// ===== core/pth_bus_if.sv
/*
  System bus between the timing/handshake end and a bus module.
  Resolves shared lines from output enables; DMA drivers come from outside.
*/
`timescale 1ns/1ps
interface pth_bus_if;
  // Timing end drivers
  logic [15:0] dev_addr;
  logic        dev_addr_oe;
  logic [7:0]  dev_data;
  logic        dev_data_oe;
  logic        dev_wr_n;
  logic        dev_wr_oe;
  logic        dev_dstb_oe;
  logic        addr_strobe_n;
  logic        mem_write_n;
  logic        sys_bus_clk_p;
  logic        sys_bus_clk_n;
  // Bus module drivers
  logic [7:0]  mod_data;
  logic        mod_data_oe;
  logic        mod_dstb_oe;
  logic        irq_n;
  logic        bus_req_n;
  logic        bus_data_disable_n;
  // DMA controller drivers
  logic [15:0] dma_addr;
  logic        dma_addr_oe;
  logic        dma_wr_n;
  logic        dma_wr_oe;
  // Resolved lines, pulled high when idle
  logic [15:0] bus_addr;
  logic [7:0]  bus_data;
  logic        write_n;
  logic        data_strobe_n;

  assign bus_addr      = dev_addr_oe ? dev_addr : (dma_addr_oe ? dma_addr : 16'hffff);
  assign bus_data      = dev_data_oe ? dev_data : (mod_data_oe ? mod_data : 8'hff);
  assign write_n       = dev_wr_oe ? dev_wr_n : (dma_wr_oe ? dma_wr_n : 1'b1);
  assign data_strobe_n = ~(dev_dstb_oe | mod_dstb_oe);

  modport dev (
    output dev_addr, dev_addr_oe, dev_data, dev_data_oe, dev_wr_n, dev_wr_oe,
    output dev_dstb_oe, addr_strobe_n, mem_write_n, sys_bus_clk_p, sys_bus_clk_n,
    input  bus_data, data_strobe_n, irq_n
  );
  modport mod (
    output mod_data, mod_data_oe, mod_dstb_oe, irq_n, bus_req_n, bus_data_disable_n,
    input  bus_addr, bus_data, write_n, data_strobe_n, addr_strobe_n, sys_bus_clk_p
  );
endinterface

// ===== core/pth_bus_module.sv
/*
  Slow memory-mapped bus module: a small byte store behind the system bus.
  Assumes the timing end launches cycles on bus clock falling edges.
*/
`timescale 1ns/1ps
module pth_bus_module #(
  parameter int          AW      = 8,
  parameter logic [15:0] BASE    = 16'h1000,
  parameter int          WR_HOLD = 6,
  parameter int          RD_WAIT = 6
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  pth_bus_if.mod    bus,
  input  wire logic irq_req_i,
  output logic      busy_o
);

  if (AW < 1 || AW > 15 || WR_HOLD < 0 || RD_WAIT < 0 ||
      WR_HOLD > int'(pth_pkg::STRETCH_EXTRA) || RD_WAIT > int'(pth_pkg::STRETCH_EXTRA)) begin : g_bad_param
    $error("pth_bus_module: parameter out of range");
  end

  typedef enum logic [2:0] {PTH_IDLE, PTH_WHOLD, PTH_RWAIT, PTH_RDRIVE, PTH_DONE} pth_mod_state_t;

  // ---------------------------------------------------------------
  // Bus clock edge and decode
  // ---------------------------------------------------------------
  logic           bclk_q_r;
  logic           fall;
  logic           sel;
  pth_mod_state_t st_r;
  logic [5:0]     cnt_r;
  logic [7:0]     mem_r [2**AW];

  assign fall = bclk_q_r & ~bus.sys_bus_clk_p; // R9
  assign sel  = ~bus.addr_strobe_n &
                (bus.bus_addr[15:AW] == BASE[15:AW]);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bclk_q_r <= 1'b0;
    end else begin
      bclk_q_r <= bus.sys_bus_clk_p;
    end
  end

  // ---------------------------------------------------------------
  // Handshake state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r  <= PTH_IDLE;
      cnt_r <= 6'h00;
    end else if (fall) begin
      unique case (st_r)
        PTH_IDLE: begin
          if (sel && !bus.write_n && !bus.data_strobe_n) begin // R4
            st_r  <= PTH_WHOLD;
            cnt_r <= 6'(WR_HOLD);
          end else if (sel && bus.write_n) begin // R4
            st_r  <= PTH_RWAIT;
            cnt_r <= 6'(RD_WAIT);
          end
        end
        PTH_WHOLD: begin
          if (cnt_r == 6'h00) begin
            st_r <= PTH_DONE;
          end else begin
            cnt_r <= cnt_r - 6'h01; // R17
          end
        end
        PTH_RWAIT: begin
          if (cnt_r == 6'h00) begin
            st_r <= PTH_RDRIVE;
          end else begin
            cnt_r <= cnt_r - 6'h01;
          end
        end
        PTH_RDRIVE: st_r <= PTH_DONE;
        PTH_DONE: begin
          if (bus.addr_strobe_n) begin
            st_r <= PTH_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (fall && st_r == PTH_IDLE && sel && !bus.write_n && !bus.data_strobe_n) begin
      mem_r[bus.bus_addr[AW-1:0]] <= bus.bus_data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.mod_data <= 8'h00;
    end else if (fall && st_r == PTH_RWAIT && cnt_r == 6'h00) begin
      bus.mod_data <= mem_r[bus.bus_addr[AW-1:0]];
    end
  end

  // ---------------------------------------------------------------
  // Bus drivers
  // ---------------------------------------------------------------
  assign bus.mod_dstb_oe        = (st_r == PTH_WHOLD) | (st_r == PTH_RDRIVE); // R17
  assign bus.mod_data_oe        = ((st_r == PTH_RDRIVE) | (st_r == PTH_DONE)) & bus.write_n & sel;
  assign bus.irq_n              = ~irq_req_i; // R1
  assign bus.bus_req_n          = 1'b1;
  assign bus.bus_data_disable_n = 1'b1;
  assign busy_o                 = st_r != PTH_IDLE;

endmodule

// ===== tb/pth_bus_props.sv
/*
  Concurrent checks on the system bus between the timing end and the bus module.
  Assumes the interface signals are wired in by name beside the interface.
*/
`timescale 1ns/1ps
module pth_bus_props (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       dev_addr_oe,
  input wire logic [7:0] dev_data,
  input wire logic       dev_data_oe,
  input wire logic       dev_wr_oe,
  input wire logic       dev_dstb_oe,
  input wire logic       addr_strobe_n,
  input wire logic       mem_write_n,
  input wire logic       sys_bus_clk_p,
  input wire logic       mod_dstb_oe,
  input wire logic       write_n,
  input wire logic       data_strobe_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ------------------------------------------------------------
  // Strobe low time
  // ------------------------------------------------------------
  logic [7:0] low_cnt_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_r <= 8'h00;
    end else begin
      low_cnt_r <= data_strobe_n ? 8'h00 : low_cnt_r + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence dstb_start;
    $rose(dev_dstb_oe);
  endsequence
  sequence one_bus_clk;
    dev_dstb_oe[*2] ##[1:3] !dev_dstb_oe;
  endsequence

  chk_addr_valid: assert property (!addr_strobe_n |-> dev_addr_oe)
    else $error("address strobe without address");
  chk_memw_copy: assert property (dev_wr_oe && !addr_strobe_n |-> mem_write_n == write_n)
    else $error("memory write differs from write line");
  chk_memw_cycle: assert property (!mem_write_n |-> !addr_strobe_n)
    else $error("memory write outside cycle");
  chk_read_high: assert property (!addr_strobe_n && !dev_data_oe |-> write_n)
    else $error("read cycle with write line low");
  chk_launch_fall: assert property ($changed(addr_strobe_n) || $changed(dev_dstb_oe)
    || $changed(mem_write_n) |-> $fell(sys_bus_clk_p))
    else $error("bus signal launched off falling edge");
  chk_dstb_write: assert property (dstb_start |-> !write_n && dev_data_oe)
    else $error("strobe without write data");
  chk_dstb_pulse: assert property (dstb_start |-> one_bus_clk)
    else $error("strobe not one bus clock");
  chk_wdata_stable: assert property (dev_dstb_oe |-> $stable(dev_data))
    else $error("write data moved under strobe");
  chk_hold_cycle: assert property (mod_dstb_oe && $past(mod_dstb_oe) && !$past(write_n) |-> !addr_strobe_n)
    else $error("cycle released under held strobe");
  chk_hold_bound: assert property (low_cnt_r <= 8'hc8)
    else $error("strobe held too long");
endmodule

// ===== tb/tb.sv
/*
  Self-checking bench: timing end and bus module joined by the bus interface.
  Assumes the design files and the property checker are compiled first.
*/
`timescale 1ns/1ps
module tb;
  logic        clk_i, rst_n_i, cpu_req_i, valid_addr_flag_i, cpu_write_i, dma_stretch_i, irq_req_i;
  logic [15:0] cpu_addr_i, cpu_restart_vec_o;
  logic [7:0]  cpu_wdata_i, cpu_rdata_o;
  logic        phase1_o, phase2_o, cpu_done_o, cpu_restart_o, cpu_irq_n_o, cpu_nmi_n_o, busy_o, bad;
  int          error_cnt, total_checks, p1, p2, n;
  int          cyc_cnt = 0;

  pth_bus_if bus ();
  pth_timing pth_timing_inst (.clk_i, .rst_n_i, .bus, .cpu_req_i, .valid_addr_flag_i, .cpu_write_i,
    .cpu_addr_i, .cpu_wdata_i, .dma_stretch_i, .phase1_o, .phase2_o, .cpu_rdata_o, .cpu_done_o,
    .cpu_restart_o, .cpu_restart_vec_o, .cpu_irq_n_o, .cpu_nmi_n_o);
  pth_bus_module pth_bus_module_inst (.clk_i, .rst_n_i, .bus, .irq_req_i, .busy_o);
  pth_bus_props pth_bus_props_inst (.clk_i, .rst_n_i, .dev_addr_oe(bus.dev_addr_oe),
    .dev_data(bus.dev_data), .dev_data_oe(bus.dev_data_oe), .dev_wr_oe(bus.dev_wr_oe),
    .dev_dstb_oe(bus.dev_dstb_oe), .addr_strobe_n(bus.addr_strobe_n), .mem_write_n(bus.mem_write_n),
    .sys_bus_clk_p(bus.sys_bus_clk_p), .mod_dstb_oe(bus.mod_dstb_oe), .write_n(bus.write_n),
    .data_strobe_n(bus.data_strobe_n));

  // ------------------------------------------------------------
  // Clock, watchdog and helpers
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #2;
  endtask
  task automatic wait_p1(input logic lvl);
    for (int k = 0; k < 400 && phase1_o !== lvl; k++) tick(1);
  endtask
  task automatic phases();
    wait_p1(1'b0);
    wait_p1(1'b1);
    for (p1 = 0; p1 < 400 && phase1_o === 1'b1; p1++) tick(1);
    for (p2 = 0; p2 < 400 && phase1_o === 1'b0; p2++) tick(1);
  endtask
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
    tick(1);
    {cpu_req_i, valid_addr_flag_i, cpu_write_i, cpu_addr_i, cpu_wdata_i} = {2'b11, wr, a, d};
    for (n = 0; n < 600 && cpu_done_o !== 1'b1; n++) tick(1);
    {cpu_req_i, valid_addr_flag_i} = 2'b00;
  endtask
  task automatic finish_test();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    error_cnt = 0;
    total_checks = 0;
    bad = 1'b0;
    {rst_n_i, cpu_req_i, valid_addr_flag_i, cpu_write_i, dma_stretch_i, irq_req_i} = 6'h00;
    {cpu_addr_i, cpu_wdata_i} = 24'h000000;
    {bus.dma_addr, bus.dma_addr_oe, bus.dma_wr_n, bus.dma_wr_oe} = {16'h2345, 3'b000};
    tick(10);
    check(16'({phase1_o, bus.addr_strobe_n}), 16'h0003);
    rst_n_i = 1'b1;
    tick(1);
    check(16'(cpu_restart_o), 16'h0001);
    check(cpu_restart_vec_o, pth_pkg::RESTART_VEC);
    n = 0;
    for (int k = 0; k < 1000; k++) begin
      p1 = int'(bus.sys_bus_clk_p);
      tick(1);
      n += p1 & int'(!bus.sys_bus_clk_p);
      bad |= (bus.sys_bus_clk_n === bus.sys_bus_clk_p);
    end
    check(16'(n inside {294, 295}), 16'h0001);
    check(16'(bad), 16'h0000);
    for (int k = 0; k < 3; k++) begin
      phases();
      check(16'(p1 inside {13, 14}), 16'h0001);
      check(16'((p1 + p2) inside {27, 28}), 16'h0001);
    end
    wait_p1(1'b0);
    wait_p1(1'b1);
    tick(3);
    {bus.dma_addr_oe, bus.dma_wr_oe} = 2'b11;
    tick(1);
    check(bus.bus_addr, 16'h2345);
    check(16'({bus.write_n, bus.dev_wr_oe}), 16'h0000);
    check(16'({phase1_o, phase2_o, busy_o}), 16'h0004);
    {bus.dma_addr_oe, bus.dma_wr_oe} = 2'b00;
    dma_stretch_i = 1'b1;
    phases();
    dma_stretch_i = 1'b0;
    check(16'(p1 inside {[180:200]}), 16'h0001);
    check(16'(p2 inside {13, 14}), 16'h0001);
    for (int k = 0; k < 3; k++) begin
      access(1'b1, 16'h1000 + 16'(k * 127), 8'h5a ^ 8'(k));
      check(16'(n < 150), 16'h0001);
      check(16'(busy_o), 16'h0001);
    end
    for (int k = 0; k < 3; k++) begin
      access(1'b0, 16'h1000 + 16'(k * 127), 8'h00);
      check(16'(cpu_rdata_o), 16'h005a ^ 16'(k));
      check(16'(n < 150), 16'h0001);
    end
    access(1'b0, 16'h4000, 8'h00);
    check(16'(n inside {[185:235]}), 16'h0001);
    check(16'(busy_o), 16'h0000);
    irq_req_i = 1'b1;
    tick(4);
    check(16'({cpu_irq_n_o, cpu_nmi_n_o}), 16'h0001);
    irq_req_i = 1'b0;
    tick(4);
    check(16'({cpu_irq_n_o, cpu_nmi_n_o}), 16'h0003);
    wait_p1(1'b0);
    tick(5);
    rst_n_i = 1'b0;
    tick(1);
    check(16'({phase1_o, bus.addr_strobe_n, bus.dev_wr_oe}), 16'h0006);
    rst_n_i = 1'b1;
    tick(1);
    check(16'(cpu_restart_o), 16'h0001);
    phases();
    check(16'(p1 inside {13, 14}), 16'h0001);
    finish_test();
  end
endmodule
